//--- design/flk_pkg.sv
// Constants and carrier types for the fault log and brownout keeper
package flk_pkg;
   localparam int RAILS = 10;
   localparam int RAIL_W = 4;
   localparam int VOLT_W = 12;
   localparam int FTYPE_W = 4;
   localparam int ENTRIES = 30;
   localparam int IDX_W = 5;
   localparam int CNT_W = 16;
   localparam int CLK_MHZ = 250;
   localparam int MS_CYC = CLK_MHZ * 1000;
   localparam logic [31:0] MS_PER_DAY = 32'h0526_5c00;
   localparam int PEAK_WIN_S = 30;
   localparam int PEAK_WIN_MS = PEAK_WIN_S * 1000;
   localparam int BO_MV = 2900;
   localparam int SUP_W = 12;
   localparam int HOLDUP_MS = 5;
   localparam int HOLDUP_CYC = HOLDUP_MS * MS_CYC;
   // Flash regions: 0 reset count, 1 clock ms, 2 clock days, 3..12 peaks, 13.. faults
   localparam logic [5:0] FA_RCNT = 6'h00;
   localparam logic [5:0] FA_MS = 6'h01;
   localparam logic [5:0] FA_DAY = 6'h02;
   localparam logic [5:0] FA_PEAK = 6'h03;
   localparam logic [5:0] FA_FLT = 6'h0d;
   localparam logic [5:0] FA_LAST = 6'h2a;
   typedef struct packed {
      logic [RAIL_W-1:0] rail;
      logic [FTYPE_W-1:0] ftype;
      logic [31:0] days;
      logic [31:0] ms;
      logic [VOLT_W-1:0] volt;
   } flk_fault_s;
   localparam int FLT_W = $bits(flk_fault_s);
   typedef struct packed {
      logic we;
      logic [5:0] addr;
      logic [FLT_W-1:0] data;
   } flk_fw_s;
endpackage

//--- design/flk_keeper.sv
// Fault, reset-count, peak and run-time clock logging with brownout save
`timescale 1ns/1ps
`default_nettype none
module flk_keeper #(
   parameter int MS_CYCLES = flk_pkg::MS_CYC,
   parameter int PEAK_MS = flk_pkg::PEAK_WIN_MS,
   parameter int HOLD_CYCLES = flk_pkg::HOLDUP_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_bo_en,
   input wire logic [flk_pkg::SUP_W-1:0] i_supply_mv,
   input wire logic i_meas_vld,
   input wire logic [flk_pkg::RAIL_W-1:0] i_meas_rail,
   input wire logic [flk_pkg::VOLT_W-1:0] i_meas_volt,
   input wire logic i_fault_vld,
   input wire logic [flk_pkg::RAIL_W-1:0] i_fault_rail,
   input wire logic [flk_pkg::FTYPE_W-1:0] i_fault_type,
   input wire logic i_rcnt_clr,
   input wire logic i_clk_wr,
   input wire logic [31:0] i_clk_ms,
   input wire logic [31:0] i_clk_days,
   input wire logic i_save_all,
   input wire logic [flk_pkg::RAIL_W-1:0] i_peak_rd_rail,
   input wire logic [flk_pkg::IDX_W-1:0] i_fault_rd_idx,
   output logic [flk_pkg::VOLT_W-1:0] o_peak_rd,
   output flk_pkg::flk_fault_s o_fault_rd,
   output logic [flk_pkg::IDX_W:0] o_fault_cnt,
   output logic [flk_pkg::CNT_W-1:0] o_rst_cnt,
   output logic [31:0] o_rtc_ms,
   output logic [31:0] o_rtc_days,
   output logic o_brownout,
   output logic o_copy_busy,
   output flk_pkg::flk_fw_s o_fw
);
   typedef enum logic [1:0] {ST_RUN, ST_COPY, ST_DONE} flk_st_e;
   localparam int FLT_W = flk_pkg::FLT_W;

   // Nonvolatile image and working RAM
   logic [flk_pkg::VOLT_W-1:0] nv_peak_ff [flk_pkg::RAILS];
   logic [flk_pkg::VOLT_W-1:0] ram_peak_ff [flk_pkg::RAILS];
   flk_pkg::flk_fault_s nv_flt_ff [flk_pkg::ENTRIES];
   flk_pkg::flk_fault_s ram_flt_ff [flk_pkg::ENTRIES];
   logic [flk_pkg::IDX_W:0] nv_fcnt_ff, ram_fcnt_ff;
   logic [flk_pkg::CNT_W-1:0] nv_rcnt_ff;
   logic [31:0] nv_ms_ff, nv_days_ff, ms_ff, days_ff;
   logic [31:0] tick_ff, win_ff;
   logic win_on_ff, booted_ff, bo_ff;
   logic [flk_pkg::RAILS-1:0] pk_ok_ff;
   logic [31:0] hold_ff;
   logic [5:0] cp_ff;
   flk_st_e st_ff;
   flk_pkg::flk_fw_s fw_ff;

   function automatic logic [FLT_W-1:0] pad12(input logic [flk_pkg::VOLT_W-1:0] v);
      pad12 = {{(FLT_W-flk_pkg::VOLT_W){1'b0}}, v};
   endfunction

   wire ms_tick = (tick_ff == 32'(MS_CYCLES - 1));
   wire day_wrap = ms_tick && (ms_ff == flk_pkg::MS_PER_DAY - 32'h1);
   // Brownout threshold
   // Supply below 2.9 V
   wire sup_low = i_supply_mv < flk_pkg::SUP_W'(flk_pkg::BO_MV);
   wire in_run = (st_ff == ST_RUN);
   wire bo_mode = i_bo_en;
   wire meas_hi = i_meas_vld && in_run && (i_meas_rail < flk_pkg::RAIL_W'(flk_pkg::RAILS))
      && (!pk_ok_ff[i_meas_rail] || (i_meas_volt > ram_peak_ff[i_meas_rail]));
   wire win_end = win_on_ff && ms_tick && (win_ff == 32'(PEAK_MS - 1));
   wire flt_ok = i_fault_vld && in_run && (ram_fcnt_ff < (flk_pkg::IDX_W+1)'(flk_pkg::ENTRIES));
   // Direct writes only with brownout mode off
   wire direct = in_run && !bo_mode;
   wire copy_last = (st_ff == ST_COPY) && (cp_ff == flk_pkg::FA_LAST);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tick_ff <= 32'h0;
         ms_ff <= 32'h0;
         days_ff <= 32'h0;
         booted_ff <= 1'b0;
      end else begin
         booted_ff <= 1'b1;
         tick_ff <= ms_tick ? 32'h0 : tick_ff + 32'h1;
         // Restore stored clock only in brownout mode
         if (!booted_ff) begin
            ms_ff <= bo_mode ? nv_ms_ff : 32'h0;
            days_ff <= bo_mode ? nv_days_ff : 32'h0;
         end else if (i_clk_wr) begin
            ms_ff <= i_clk_ms;
            days_ff <= i_clk_days;
         end else if (ms_tick && in_run) begin
            ms_ff <= day_wrap ? 32'h0 : ms_ff + 32'h1;
            days_ff <= day_wrap ? days_ff + 32'h1 : days_ff;
         end
      end
   end

   // Peak window and working peaks
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         win_on_ff <= 1'b0;
         win_ff <= 32'h0;
         pk_ok_ff <= '0;
      end else begin
         if (meas_hi)
            pk_ok_ff[i_meas_rail] <= 1'b1;
         if (meas_hi && !win_on_ff && !bo_mode) begin
            win_on_ff <= 1'b1;
            win_ff <= 32'h0;
         end else if (win_end) begin
            win_on_ff <= 1'b0;
         end else if (win_on_ff && ms_tick) begin
            win_ff <= win_ff + 32'h1;
         end
      end
   end

   // Peaks and faults gather in RAM
   always_ff @(posedge i_clk) begin
      if (meas_hi)
         ram_peak_ff[i_meas_rail] <= i_meas_volt;
      if (flt_ok)
         ram_flt_ff[ram_fcnt_ff[flk_pkg::IDX_W-1:0]] <= '{rail: i_fault_rail,
            ftype: i_fault_type, days: days_ff, ms: ms_ff,
            volt: ram_peak_ff[i_fault_rail]};
   end

   // Nonvolatile image updates
   always_ff @(posedge i_clk) begin
      for (int k = 0; k < flk_pkg::RAILS; k++) begin
         if (pk_ok_ff[k] && ((win_end && direct) || copy_last))
            nv_peak_ff[k] <= ram_peak_ff[k];
      end
      if (flt_ok && direct)
         nv_flt_ff[ram_fcnt_ff[flk_pkg::IDX_W-1:0]] <= '{rail: i_fault_rail,
            ftype: i_fault_type, days: days_ff, ms: ms_ff,
            volt: ram_peak_ff[i_fault_rail]};
      if (copy_last)
         nv_flt_ff <= ram_flt_ff;
      if ((i_save_all && in_run) || copy_last) begin
         nv_ms_ff <= ms_ff;
         nv_days_ff <= days_ff;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ram_fcnt_ff <= '0;
         nv_fcnt_ff <= '0;
         nv_rcnt_ff <= '0;
      end else begin
         if (flt_ok)
            ram_fcnt_ff <= ram_fcnt_ff + 1'b1;
         if (flt_ok && direct)
            nv_fcnt_ff <= ram_fcnt_ff + 1'b1;
         if (i_rcnt_clr)
            nv_rcnt_ff <= '0;
         else if (!booted_ff)
            nv_rcnt_ff <= nv_rcnt_ff + 1'b1;
         if (copy_last)
            nv_fcnt_ff <= ram_fcnt_ff;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_ff <= ST_RUN;
         cp_ff <= 6'h0;
         hold_ff <= 32'h0;
         bo_ff <= 1'b0;
      end else begin
         case (st_ff)
            ST_RUN: begin
               if (sup_low && bo_mode && booted_ff) begin
                  st_ff <= ST_COPY;
                  bo_ff <= 1'b1;
                  cp_ff <= 6'h0;
                  hold_ff <= 32'h0;
               end
            end
            ST_COPY: begin
               hold_ff <= hold_ff + 32'h1;
               cp_ff <= cp_ff + 6'h1;
               if (copy_last || hold_ff == 32'(HOLD_CYCLES - 1))
                  st_ff <= ST_DONE;
            end
            ST_DONE: st_ff <= ST_DONE;
            default: st_ff <= ST_RUN;
         endcase
      end
   end

   // Flash write port
   wire [FLT_W-1:0] cp_data = (cp_ff == flk_pkg::FA_RCNT) ? FLT_W'(nv_rcnt_ff) :
      (cp_ff == flk_pkg::FA_MS) ? FLT_W'(ms_ff) :
      (cp_ff == flk_pkg::FA_DAY) ? FLT_W'(days_ff) :
      (cp_ff < flk_pkg::FA_FLT) ? pad12(ram_peak_ff[4'(cp_ff - flk_pkg::FA_PEAK)]) :
      ram_flt_ff[5'(cp_ff - flk_pkg::FA_FLT)];
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         fw_ff <= '0;
      else if (st_ff == ST_COPY)
         fw_ff <= '{we: 1'b1, addr: cp_ff, data: cp_data};
      else
         fw_ff <= '{we: 1'b0, addr: 6'h0, data: '0};
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_peak_rd <= '0;
         o_fault_rd <= '0;
      end else begin
         o_peak_rd <= nv_peak_ff[i_peak_rd_rail];
         o_fault_rd <= nv_flt_ff[i_fault_rd_idx];
      end
   end

   assign o_fault_cnt = nv_fcnt_ff;
   assign o_rst_cnt = nv_rcnt_ff;
   assign o_rtc_ms = ms_ff;
   assign o_rtc_days = days_ff;
   assign o_brownout = bo_ff;
   assign o_copy_busy = (st_ff == ST_COPY);
   assign o_fw = fw_ff;
endmodule
`default_nettype wire

//--- testbench/flk_keeper_assertions.sv
// Port checker for the fault log keeper
`timescale 1ns/1ps
`default_nettype none
module flk_keeper_assertions #(parameter int HOLD_CYCLES = 100) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_bo_en,
   input wire logic [11:0] i_supply_mv,
   input wire logic i_rcnt_clr,
   input wire logic i_clk_wr,
   input wire logic [31:0] i_clk_ms,
   input wire logic [31:0] i_clk_days,
   input wire logic [5:0] o_fault_cnt,
   input wire logic [15:0] o_rst_cnt,
   input wire logic [31:0] o_rtc_ms,
   input wire logic [31:0] o_rtc_days,
   input wire logic o_brownout,
   input wire logic o_copy_busy,
   input wire flk_pkg::flk_fw_s o_fw
);
   int busy_ff;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy_ff <= 0;
      end else begin
         busy_ff <= o_copy_busy ? busy_ff + 1 : 0;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   chk_bo_detect: assert property (i_bo_en && i_supply_mv < 12'hb54 |=> o_brownout)
      else $error("brownout not declared");
   chk_bo_sticky: assert property (o_brownout |=> o_brownout)
      else $error("brownout flag dropped");
   chk_copy_first: assert property ($rose(o_brownout) |-> o_copy_busy ##1 (o_fw.we && o_fw.addr == 6'h00))
      else $error("copy did not start at word zero");
   chk_copy_order: assert property (o_brownout && o_fw.we && o_fw.addr < 6'h2a |=> o_fw.we && o_fw.addr == $past(o_fw.addr) + 6'h01)
      else $error("copy words out of order");
   chk_copy_time: assert property (busy_ff <= HOLD_CYCLES)
      else $error("copy too long");
   chk_quiet_bo: assert property ($past(i_bo_en) && i_bo_en && !o_brownout |-> !o_fw.we)
      else $error("flash write in brownout mode");
   chk_cnt_clear: assert property (i_rcnt_clr |=> o_rst_cnt == 16'h0000)
      else $error("reset count not cleared");
   chk_rtc_load: assert property (i_clk_wr |=> o_rtc_ms == $past(i_clk_ms) && o_rtc_days == $past(i_clk_days))
      else $error("clock write not taken");
   chk_log_limit: assert property (o_fault_cnt <= 6'h1e)
      else $error("fault count above capacity");
   cover property ($rose(o_brownout));
   cover property (i_rcnt_clr);
   cover property (i_clk_wr);
endmodule
`default_nettype wire

//--- testbench/flk_host_model.sv
// Host side model: option bit, count clear, clock writes, log reads
`timescale 1ns/1ps
`default_nettype none
module flk_host_model (
   input wire logic i_clk,
   output logic o_bo_en,
   output logic o_rcnt_clr,
   output logic o_clk_wr,
   output logic [31:0] o_clk_ms,
   output logic [31:0] o_clk_days,
   output logic o_save_all,
   output logic [3:0] o_peak_rail,
   output logic [4:0] o_flt_idx
);
   initial begin
      o_bo_en = 1'b0;
      o_rcnt_clr = 1'b0;
      o_clk_wr = 1'b0;
      o_clk_ms = 32'h0;
      o_clk_days = 32'h0;
      o_save_all = 1'b0;
      o_peak_rail = 4'h0;
      o_flt_idx = 5'h0;
   end
   task set_bo(input logic en);
      @(negedge i_clk) o_bo_en = en;
   endtask
   task clear_count();
      @(negedge i_clk) o_rcnt_clr = 1'b1;
      @(negedge i_clk) o_rcnt_clr = 1'b0;
   endtask
   task write_clock(input logic [31:0] ms, input logic [31:0] days);
      @(negedge i_clk) o_clk_wr = 1'b1;
      o_clk_ms = ms;
      o_clk_days = days;
      @(negedge i_clk) o_clk_wr = 1'b0;
      o_clk_ms = ~ms;
      o_clk_days = ~days;
   endtask
   task save_all();
      @(negedge i_clk) o_save_all = 1'b1;
      @(negedge i_clk) o_save_all = 1'b0;
   endtask
   task select(input logic [3:0] r, input logic [4:0] i);
      @(negedge i_clk) o_peak_rail = r;
      o_flt_idx = i;
   endtask
endmodule
`default_nettype wire

//--- testbench/flk_keeper_bench.sv
// Self-checking bench for the fault log keeper
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module flk_keeper_bench;
   logic i_clk, i_nrst, i_bo_en, i_meas_vld, i_fault_vld, i_rcnt_clr, i_clk_wr, i_save_all;
   logic [11:0] i_supply_mv, i_meas_volt, o_peak_rd;
   logic [3:0] i_meas_rail, i_fault_rail, i_fault_type, i_peak_rd_rail;
   logic [31:0] i_clk_ms, i_clk_days, o_rtc_ms, o_rtc_days;
   logic [4:0] i_fault_rd_idx;
   logic [5:0] o_fault_cnt, wlast;
   logic [15:0] o_rst_cnt;
   logic o_brownout, o_copy_busy;
   flk_pkg::flk_fault_s o_fault_rd;
   flk_pkg::flk_fw_s o_fw;
   int checks = 0, fail_count = 0, wcnt;
   flk_keeper #(.MS_CYCLES(4), .PEAK_MS(3), .HOLD_CYCLES(100)) u_flk_keeper (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_bo_en(i_bo_en), .i_supply_mv(i_supply_mv),
      .i_meas_vld(i_meas_vld), .i_meas_rail(i_meas_rail), .i_meas_volt(i_meas_volt),
      .i_fault_vld(i_fault_vld), .i_fault_rail(i_fault_rail), .i_fault_type(i_fault_type),
      .i_rcnt_clr(i_rcnt_clr), .i_clk_wr(i_clk_wr), .i_clk_ms(i_clk_ms),
      .i_clk_days(i_clk_days), .i_save_all(i_save_all), .i_peak_rd_rail(i_peak_rd_rail),
      .i_fault_rd_idx(i_fault_rd_idx), .o_peak_rd(o_peak_rd), .o_fault_rd(o_fault_rd),
      .o_fault_cnt(o_fault_cnt), .o_rst_cnt(o_rst_cnt), .o_rtc_ms(o_rtc_ms),
      .o_rtc_days(o_rtc_days), .o_brownout(o_brownout), .o_copy_busy(o_copy_busy),
      .o_fw(o_fw));
   flk_host_model u_flk_host_model (.i_clk(i_clk), .o_bo_en(i_bo_en), .o_rcnt_clr(i_rcnt_clr),
      .o_clk_wr(i_clk_wr), .o_clk_ms(i_clk_ms), .o_clk_days(i_clk_days), .o_save_all(i_save_all),
      .o_peak_rail(i_peak_rd_rail), .o_flt_idx(i_fault_rd_idx));
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   task automatic results();
      $display("checks %0d fails %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      i_nrst = 1'b0;
      repeat (3) @(negedge i_clk);
      i_nrst = 1'b1;
   endtask
   task automatic watch(input int n, input logic [5:0] a);
      wcnt = 0;
      repeat (n) begin
         @(posedge i_clk);
         #1;
         if (o_fw.we === 1'b1 && (a == 6'h3f || o_fw.addr == a)) begin
            wcnt++;
            wlast = o_fw.addr;
         end
      end
   endtask
   task automatic ev(input logic f, input logic [3:0] r, input logic [11:0] v);
      @(negedge i_clk);
      i_meas_vld = !f;
      i_fault_vld = f;
      i_meas_rail = r;
      i_fault_rail = r;
      i_meas_volt = v;
      i_fault_type = v[3:0];
      @(negedge i_clk);
      i_meas_vld = 1'b0;
      i_fault_vld = 1'b0;
   endtask
   task automatic t_basic();
      repeat (10) @(negedge i_clk);
      `CHK(o_rst_cnt, 16'h0001)
      `CHK(o_rtc_days, 32'h0)
      u_flk_host_model.write_clock(flk_pkg::MS_PER_DAY - 32'h1, 32'h5);
      repeat (10) @(negedge i_clk);
      `CHK(o_rtc_days, 32'h6)
      u_flk_host_model.save_all();
      u_flk_host_model.clear_count();
      `CHK(o_rst_cnt, 16'h0000)
      $display("basic done");
   endtask
   task automatic t_peak();
      u_flk_host_model.select(4'h2, 5'h0);
      ev(1'b0, 4'h2, 12'h064);
      ev(1'b0, 4'h2, 12'h12c);
      ev(1'b0, 4'h2, 12'h0c8);
      repeat (20) @(negedge i_clk);
      `CHK(o_peak_rd, 12'h12c)
      ev(1'b0, 4'h2, 12'h200);
      ev(1'b0, 4'h2, 12'h150);
      `CHK(o_peak_rd, 12'h12c)
      repeat (20) @(negedge i_clk);
      `CHK(o_peak_rd, 12'h200)
      $display("peak done");
   endtask
   task automatic t_fault();
      ev(1'b0, 4'h3, 12'h123);
      ev(1'b1, 4'h3, 12'h002);
      repeat (3) @(negedge i_clk);
      `CHK(o_fault_cnt, 6'h01)
      `CHK(o_fault_rd.rail, 4'h3)
      `CHK(o_fault_rd.ftype, 4'h2)
      `CHK(o_fault_rd.volt, 12'h123)
      `CHK(o_fault_rd.days, 32'h6)
      repeat (31) ev(1'b1, 4'h1, 12'h001);
      repeat (3) @(negedge i_clk);
      `CHK(o_fault_cnt, 6'h1e)
      $display("fault done");
   endtask
   task automatic t_brown();
      u_flk_host_model.set_bo(1'b1);
      do_reset();
      ev(1'b0, 4'h5, 12'h200);
      ev(1'b1, 4'h5, 12'h003);
      `CHK(o_rtc_days, 32'h6)
      i_supply_mv = 12'hb54;
      watch(20, 6'h3f);
      `CHK(wcnt, 0)
      `CHK(o_brownout, 1'b0)
      fork
         @(negedge i_clk) i_supply_mv = 12'hb53;
         watch(120, 6'h3f);
      join
      `CHK(wcnt, 43)
      `CHK(wlast, flk_pkg::FA_LAST)
      `CHK(o_copy_busy, 1'b0)
      `CHK(o_brownout, 1'b1)
      $display("brownout done");
   endtask
   initial begin
      i_nrst = 1'b0;
      i_supply_mv = 12'hce4;
      i_meas_vld = 1'b0;
      i_fault_vld = 1'b0;
      i_meas_rail = 4'h0;
      i_fault_rail = 4'h0;
      i_meas_volt = 12'h000;
      i_fault_type = 4'h0;
      do_reset();
      t_basic();
      t_peak();
      t_fault();
      t_brown();
      results();
   end
endmodule
bind flk_keeper flk_keeper_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_flk_keeper_assertions (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_bo_en(i_bo_en), .i_supply_mv(i_supply_mv),
   .i_rcnt_clr(i_rcnt_clr), .i_clk_wr(i_clk_wr), .i_clk_ms(i_clk_ms), .i_clk_days(i_clk_days),
   .o_fault_cnt(o_fault_cnt), .o_rst_cnt(o_rst_cnt), .o_rtc_ms(o_rtc_ms),
   .o_rtc_days(o_rtc_days), .o_brownout(o_brownout), .o_copy_busy(o_copy_busy), .o_fw(o_fw));
`default_nettype wire
